//--- pkg/termio_defs.svh
// constants for the digital terminal processing block
`ifndef TERMIO_DEFS_SVH
`define TERMIO_DEFS_SVH
`define N_BIDIR 4
`define N_OUTONLY 3
`define N_CHAN 7
`define IDX_DISC 10'h190
`define IDX_MAX 10'h2D0
`define PURE_MAX 16'sh7530
`define OFS_STATUS 12'h080
`define WD_CFG 2'h0
`define WD_THR 2'h1
`define WD_HILO 2'h2
`define WD_DEST 2'h3
`define B_RECT 0
`define B_INV 1
`define B_DRV 2
`define SRC_LSB 16
`define RST_HI 16'sh0001
`define RST_LO 16'sh0000
`define RST_THR 16'sh0000
`define RST_RECT_BIDIR 1'b0
`define RST_RECT_OUTONLY 1'b1
`define CLK_PERIOD_NS 5
`define BLK_PERIOD_NS 1000
`define BLK_CYCLES ((`BLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- pkg/termio_pkg.sv
// types shared by the digital terminal processing block
package termio_pkg;
   typedef logic signed [15:0] pure_t;
   typedef struct packed
   {
      logic wr;
      logic [9:0] idx;
      logic signed [15:0] val;
   } dest_req_t;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_FETCH = 4'h2,
      ST_INPUT = 4'h4,
      ST_WRITE = 4'h8
   } seq_state_t;
endpackage

//--- rtl/out_path.sv
// rectify, strict compare and invert chain of one output path
`timescale 1ns/1ps
module out_path
(
   input wire logic signed [15:0] src_val,
   input wire logic signed [15:0] thresh,
   input wire logic rectify,
   input wire logic invert,
   output logic result
);
   logic signed [16:0] wide;
   logic signed [16:0] mag;
   logic signed [16:0] thr_w;

   // one extra bit so the magnitude of the most negative value cannot wrap
   assign wide = {src_val[15], src_val};
   assign thr_w = {thresh[15], thresh};
   assign mag = (rectify && wide < 0) ? -wide : wide;
   assign result = (mag > thr_w) ^ invert;
endmodule

//--- rtl/pin_sync.sv
// three-stage terminal synchroniser, level moves when stages two and three agree
`timescale 1ns/1ps
module pin_sync
(
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // stage one feeds stage two only; agreement filters a single-cycle glitch
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            level <= s3_q;
      end
   end
endmodule

//--- rtl/termio_top.sv
// digital terminal processing: four bidirectional and three output-only terminals
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "termio_defs.svh"
module termio_top
#(
   parameter int BLOCK_CYCLES = `BLK_CYCLES
)
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3:0] TERM_IN,
   output logic [3:0] TERM_OUT,
   output logic [3:0] TERM_OE_N,
   output logic [2:0] OUT_TERM,
   output logic [6:0] RESULT_BITS,
   output logic [9:0] PARAM_IDX,
   input wire termio_pkg::pure_t PARAM_VAL,
   input wire termio_pkg::pure_t DEST_MIN,
   input wire termio_pkg::pure_t DEST_MAX,
   output termio_pkg::dest_req_t DEST_REQ
);
   import termio_pkg::*;

   localparam int CW = $clog2(BLOCK_CYCLES);

   // one pass needs 7 fetch plus 8 input cycles; a shorter period would overrun
   generate
      if (BLOCK_CYCLES < 16)
      begin : g_bad_period
         $error("BLOCK_CYCLES too small for one processing pass");
      end
   endgenerate

   function automatic pure_t clamp(input pure_t v, input pure_t lo, input pure_t hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [9:0] idx_lim(input logic [9:0] v);
      idx_lim = (v > `IDX_MAX) ? `IDX_MAX : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration state
   logic [7:0] rect_q;
   logic [7:0] inv_q;
   logic [3:0] drv_q;
   logic [9:0] src_q [8];
   pure_t thr_q [8];
   pure_t hi_q [4];
   pure_t lo_q [4];
   logic [9:0] dest_q [4];
   logic [6:0] res_q;
   logic [3:0] sensed;
   seq_state_t state_q;
   seq_state_t state_d;
   logic [2:0] ch_q;
   logic [2:0] ch_d;
   logic [CW-1:0] blk_cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode and read selection
   wire [2:0] a_ch = PADDR[6:4];
   wire [1:0] a_bi = PADDR[5:4];
   wire [1:0] a_wd = PADDR[3:2];
   wire is_stat = (PADDR[11:2] == 10'(`OFS_STATUS >> 2));
   wire is_bidir = (PADDR[11:6] == 6'h00);
   wire is_chan = (PADDR[11:7] == 5'h00) && (a_ch < 3'h7) && (is_bidir || a_wd < 2'h2);
   wire mapped = is_chan || is_stat;
   wire setup = PSEL && !PENABLE;
   wire wr_en = PSEL && PENABLE && PREADY && PWRITE && is_chan;
   wire drv_rd = is_bidir ? drv_q[a_bi] : 1'b0;
   wire [31:0] rd_cfg = {6'h0, src_q[a_ch], 13'h0, drv_rd, inv_q[a_ch], rect_q[a_ch]};
   wire [31:0] rd_thr = {{16{thr_q[a_ch][15]}}, thr_q[a_ch]};
   wire [31:0] rd_hilo = {lo_q[a_bi], hi_q[a_bi]};
   wire [31:0] rd_dest = {22'h0, dest_q[a_bi]};
   wire [31:0] rd_stat = {20'h00000, sensed, 1'b0, res_q};
   wire [31:0] rd_word = is_stat ? rd_stat :
                         (a_wd == `WD_CFG) ? rd_cfg :
                         (a_wd == `WD_THR) ? rd_thr :
                         (a_wd == `WD_HILO) ? rd_hilo : rd_dest;

   // no wait state: answer is prepared in the setup cycle
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY <= setup;
         PSLVERR <= setup && !mapped;
         PRDATA <= (setup && mapped && !PWRITE) ? rd_word : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes; linear fields clamp to the pure-number range
   wire pure_t wr_lo = PWDATA[15:0];
   wire pure_t wr_hi = PWDATA[31:16];

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         rect_q <= {1'b0, {3{`RST_RECT_OUTONLY}}, {4{`RST_RECT_BIDIR}}};
         inv_q <= 8'h00;
         drv_q <= 4'h0;
         for (int i = 0; i < 8; i++)
         begin
            src_q[i] <= `IDX_DISC;
            thr_q[i] <= `RST_THR;
         end
         for (int i = 0; i < 4; i++)
         begin
            hi_q[i] <= `RST_HI;
            lo_q[i] <= `RST_LO;
            dest_q[i] <= `IDX_DISC;
         end
      end
      else if (wr_en)
      begin
         case (a_wd)
            `WD_CFG:
            begin
               rect_q[a_ch] <= PWDATA[`B_RECT];
               inv_q[a_ch] <= PWDATA[`B_INV];
               if (is_bidir)
                  drv_q[a_bi] <= PWDATA[`B_DRV];
               src_q[a_ch] <= idx_lim(PWDATA[`SRC_LSB+9:`SRC_LSB]);
            end
            `WD_THR: thr_q[a_ch] <= clamp(wr_lo, -`PURE_MAX, `PURE_MAX);
            `WD_HILO:
            begin
               hi_q[a_bi] <= clamp(wr_lo, -`PURE_MAX, `PURE_MAX);
               lo_q[a_bi] <= clamp(wr_hi, -`PURE_MAX, `PURE_MAX);
            end
            default: dest_q[a_bi] <= idx_lim(PWDATA[9:0]);
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // terminal input sensing, always active whatever the drive setting
   genvar gi;
   generate
      for (gi = 0; gi < `N_BIDIR; gi++)
      begin : g_sense
         pin_sync u_sync
         (
            .clk(MCLK),
            .rst(RST),
            .din(TERM_IN[gi]),
            .level(sensed[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // block cycle timer and processing sequencer
   wire tick = (blk_cnt_q == CW'(BLOCK_CYCLES - 1));
   wire pure_t pv = clamp(PARAM_VAL, -`PURE_MAX, `PURE_MAX);
   wire [1:0] bch = ch_q[1:0];
   wire pure_t sel_val = sensed[bch] ? hi_q[bch] : lo_q[bch];
   wire last_out = (ch_q == 3'h6);
   wire last_in = (ch_q == 3'h3);
   logic cur_res;

   // one shared chain, time-multiplexed over all seven outputs
   out_path u_path
   (
      .src_val(pv),
      .thresh(thr_q[ch_q]),
      .rectify(rect_q[ch_q]),
      .invert(inv_q[ch_q]),
      .result(cur_res)
   );

   // next state of the pass: outputs first, then inputs
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (tick) state_d = ST_FETCH;
         ST_FETCH: if (last_out) state_d = ST_INPUT;
         ST_INPUT: state_d = ST_WRITE;
         ST_WRITE: state_d = last_in ? ST_IDLE : ST_INPUT;
         default: state_d = ST_IDLE;
      endcase
   end

   assign ch_d = ((state_q == ST_FETCH && !last_out) || (state_q == ST_WRITE && !last_in)) ?
                 ch_q + 3'h1 : ((state_q == ST_INPUT) ? ch_q : 3'h0);

   // sequencer registers; the source index is taken from ch_d so it appears in the same cycle as the fetch
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         state_q <= ST_IDLE;
         ch_q <= 3'h0;
         blk_cnt_q <= '0;
         PARAM_IDX <= `IDX_DISC;
      end
      else
      begin
         state_q <= state_d;
         ch_q <= ch_d;
         blk_cnt_q <= tick ? '0 : blk_cnt_q + CW'(1);
         PARAM_IDX <= src_q[ch_d];
      end
   end

   // results update every pass, drive enable plays no part here
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         res_q <= 7'h00;
      else if (state_q == ST_FETCH)
         res_q[ch_q] <= cur_res;
   end

   // destination transfer; limits answer for the index held one cycle earlier
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         DEST_REQ <= '{wr: 1'b0, idx: `IDX_DISC, val: 16'sh0000};
      else if (state_q == ST_INPUT)
      begin
         DEST_REQ.wr <= 1'b0;
         DEST_REQ.idx <= dest_q[bch];
      end
      else if (state_q == ST_WRITE)
      begin
         DEST_REQ.wr <= (DEST_REQ.idx != `IDX_DISC);
         DEST_REQ.val <= clamp(sel_val, DEST_MIN, DEST_MAX);
      end
      else
         DEST_REQ.wr <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers: enable only while drive is on and the result is high
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         TERM_OE_N <= 4'hF;
         TERM_OUT <= 4'h0;
         OUT_TERM <= 3'h0;
         RESULT_BITS <= 7'h00;
      end
      else
      begin
         TERM_OE_N <= ~(drv_q & res_q[3:0]);
         TERM_OUT <= res_q[3:0];
         OUT_TERM <= res_q[6:4];
         RESULT_BITS <= res_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_oe_follows_res: assert property (@(posedge MCLK) disable iff (RST)
      ##1 TERM_OE_N == ~($past(drv_q) & $past(res_q[3:0])))
      else $error("terminal enable does not follow drive and result");

   a_off_no_drive: assert property (@(posedge MCLK) disable iff (RST)
      (drv_q == 4'h0) [*2] |-> TERM_OE_N == 4'hF)
      else $error("terminal driven while drive disabled");

   a_cmp_equal_low: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_FETCH && !inv_q[ch_q] && !rect_q[ch_q] && pv == thr_q[ch_q])
      |-> !cur_res)
      else $error("equal compare gave high");

   a_rect_neg_high: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_FETCH && rect_q[ch_q] && !inv_q[ch_q] && pv < 0 && thr_q[ch_q] >= 0
       && -pv > thr_q[ch_q]) |=> res_q[$past(ch_q)])
      else $error("rectified negative value not high");

   a_pass_timing: assert property (@(posedge MCLK) disable iff (RST)
      (state_q == ST_IDLE && tick) |=> state_q == ST_FETCH ##7 state_q == ST_INPUT)
      else $error("processing pass out of step");

   a_disc_no_write: assert property (@(posedge MCLK) disable iff (RST)
      DEST_REQ.wr |-> DEST_REQ.idx != `IDX_DISC && $past(state_q) == ST_WRITE)
      else $error("write issued to disconnected destination");

   a_dest_clamped: assert property (@(posedge MCLK) disable iff (RST)
      DEST_REQ.wr |-> DEST_REQ.val >= $past(DEST_MIN) && DEST_REQ.val <= $past(DEST_MAX))
      else $error("destination value outside its limits");

   a_thr_range: assert property (@(posedge MCLK) disable iff (RST)
      thr_q[ch_q] <= `PURE_MAX && thr_q[ch_q] >= -`PURE_MAX)
      else $error("threshold outside pure-number range");

   a_outonly_res: assert property (@(posedge MCLK) disable iff (RST)
      ##1 OUT_TERM == $past(res_q[6:4]) && RESULT_BITS == $past(res_q))
      else $error("output-only terminals stale");

   a_apb_ready: assert property (@(posedge MCLK) disable iff (RST)
      setup |=> PREADY ##1 !PREADY)
      else $error("apb ready not one cycle after setup");
endmodule

//--- tb/field_model.sv
// field wiring model: wired-OR terminals, parameter table and destination limits
`timescale 1ns/1ps
module field_model
(
   input wire logic MCLK,
   input wire logic [3:0] TERM_OUT,
   input wire logic [3:0] TERM_OE_N,
   input wire logic [3:0] ext_hi,
   input wire logic [9:0] PARAM_IDX,
   output termio_pkg::pure_t PARAM_VAL,
   output termio_pkg::pure_t DEST_MIN,
   output termio_pkg::pure_t DEST_MAX,
   input wire termio_pkg::dest_req_t DEST_REQ,
   output logic [3:0] TERM_IN
);
   import termio_pkg::*;
   pure_t table_q [0:720];
   logic [9:0] last_idx = 10'h000;
   pure_t last_val = 16'sh0000;
   int wr_count = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // pins pulled low; any driver or outside device pulls high
   assign TERM_IN = (~TERM_OE_N & TERM_OUT) | ext_hi;
   // lookup answers the same cycle; out-of-table indices read zero
   assign PARAM_VAL = (PARAM_IDX <= 10'h2D0) ? table_q[PARAM_IDX] : 16'sh0000;
   // index 500 stands for a narrow 0..6000 parameter, the rest span the full range
   assign DEST_MIN = (DEST_REQ.idx == 10'h1F4) ? 16'sh0000 : -16'sh7530;
   assign DEST_MAX = (DEST_REQ.idx == 10'h1F4) ? 16'sh1770 : 16'sh7530;
   initial
   begin
      for (int i = 0; i <= 720; i++) table_q[i] = 16'sh0000;
   end
   task automatic set_val(input int idx, input pure_t v);
      table_q[idx] <= v;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // record every destination store
   always @(posedge MCLK)
   begin
      if (DEST_REQ.wr === 1'b1)
      begin
         last_idx <= DEST_REQ.idx;
         last_val <= DEST_REQ.val;
         wr_count <= wr_count + 1;
      end
   end
endmodule

//--- tb/digital_terminal_io_processing_tb.sv
// self-checking bench for the digital terminal processing block
`timescale 1ns/1ps
`include "termio_defs.svh"
module digital_terminal_io_processing_tb;
   import termio_pkg::*;
   localparam int BC = 20;
   logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic [3:0] term_in, term_out, term_oe_n, ext_hi = 4'h0;
   logic [2:0] out_term;
   logic [6:0] result_bits;
   logic [9:0] param_idx;
   pure_t param_val, dest_min, dest_max;
   dest_req_t dest_req;
   int mismatches = 0, checks_done = 0, cycles = 0, wc;
   ////////////////////////////////////////////////////////////////////////////////
   termio_top #(.BLOCK_CYCLES(BC)) termio_top_inst (.MCLK(mclk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TERM_IN(term_in), .TERM_OUT(term_out),
      .TERM_OE_N(term_oe_n), .OUT_TERM(out_term), .RESULT_BITS(result_bits),
      .PARAM_IDX(param_idx), .PARAM_VAL(param_val), .DEST_MIN(dest_min),
      .DEST_MAX(dest_max), .DEST_REQ(dest_req));
   field_model field_model_inst (.MCLK(mclk), .TERM_OUT(term_out), .TERM_OE_N(term_oe_n),
      .ext_hi(ext_hi), .PARAM_IDX(param_idx), .PARAM_VAL(param_val), .DEST_MIN(dest_min),
      .DEST_MAX(dest_max), .DEST_REQ(dest_req), .TERM_IN(term_in));
   initial
   begin
      forever #2.5 mclk = ~mclk;
   end
   // hang guard: the whole run needs about 1100 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one APB transfer; an idle edge follows so the next setup lands on a new edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // this wait ends on pready, or on the bench timeout if pready never comes
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // three block periods cover sync latency plus a full pass
   task automatic settle;
      repeat (3 * BC + 8) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(32'(term_oe_n), 32'hF);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0190_0000);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0190_0001);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0000_0190);
      apb(1'b1, 12'h048, 32'h1234);
      chk({31'h0, err}, 32'h1);
   endtask
   // strict compare, rectify and invert on channel 0 with its pin left undriven
   task automatic t_compare;
      pure_t v[6] = '{16'sd100, 16'sd101, -16'sd150, -16'sd150, 16'sd101, -16'sd1};
      pure_t th[6] = '{16'sd100, 16'sd100, 16'sd100, 16'sd100, 16'sd100, 16'sd0};
      logic [1:0] ri[6] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b01};
      logic ex[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++)
      begin
         field_model_inst.set_val(10, v[i]);
         apb(1'b1, 12'h000, 32'h000A_0000 | 32'(ri[i]));
         apb(1'b1, 12'h004, 32'(th[i]));
         settle();
         chk(32'(result_bits[0]), 32'(ex[i]));
         chk(32'(term_out[0]), 32'(ex[i]));
         chk(32'(term_oe_n[0]), 32'h1);
      end
   endtask
   // drive enable on channel 1; the input is still sensed while the pin is driven
   task automatic t_drive;
      field_model_inst.set_val(11, 16'sd50);
      apb(1'b1, 12'h010, 32'h000B_0004);
      settle();
      chk(32'(term_oe_n[1]), 32'h0);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd & 32'h202, 32'h202);
      field_model_inst.set_val(11, 16'sd0);
      ext_hi <= 4'h2;
      settle();
      chk(32'(term_oe_n[1]), 32'h1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd & 32'h202, 32'h200);
      ext_hi <= 4'h0;
   endtask
   // inverted input sense, clamping at the destination and disconnect on channel 2
   task automatic t_input;
      apb(1'b1, 12'h028, 32'h0001_0000);
      apb(1'b1, 12'h02C, 32'h0000_01F4);
      settle();
      chk(32'(field_model_inst.last_idx), 32'h1F4);
      chk(32'(field_model_inst.last_val), 32'h1);
      ext_hi <= 4'h4;
      settle();
      chk(32'(field_model_inst.last_val), 32'h0);
      apb(1'b1, 12'h028, 32'h0001_4E20);
      settle();
      chk(32'(field_model_inst.last_val), 32'h1770);
      apb(1'b1, 12'h02C, 32'h0000_0190);
      repeat (BC) @(posedge mclk);
      wc = field_model_inst.wr_count;
      settle();
      chk(32'(field_model_inst.wr_count), 32'(wc));
      ext_hi <= 4'h0;
   endtask
   // output-only channel 5 with its threshold clamp, source index clamp on channel 6
   task automatic t_outonly;
      field_model_inst.set_val(12, -16'sd200);
      apb(1'b1, 12'h050, 32'h000C_0001);
      apb(1'b1, 12'h054, 32'h0000_0064);
      settle();
      chk(32'(out_term[1]), 32'h1);
      chk(32'(result_bits[5]), 32'h1);
      apb(1'b1, 12'h050, 32'h000C_0000);
      settle();
      chk(32'(out_term[1]), 32'h0);
      apb(1'b1, 12'h054, 32'hFFFF_8ACF);
      apb(1'b0, 12'h054, 32'h0);
      chk(rd, 32'hFFFF_8AD0);
      apb(1'b1, 12'h060, 32'h03FF_0001);
      apb(1'b0, 12'h060, 32'h0);
      chk(rd, 32'h02D0_0001);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_compare();
      t_drive();
      t_input();
      t_outonly();
      conclude();
   end
endmodule
